// ### core/irq_cfg_pkg.sv
// shared constants for the external interrupt pin and priority configuration block
package irq_cfg_pkg;
  // -------------------------------------------------------------------------
  // special-function register addresses
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_EXT_INT_PIN_CONFIG       = 8'h00_E4;
  localparam logic [7:0] ADDR_EXTENDED_PRIORITY_SECOND = 8'h00_F7;
  localparam logic [7:0] ADDR_PORT_ZERO_SKIP_MASK      = 8'h00_D4;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] RST_EXT_INT_PIN_CONFIG        = 8'h00_00;
  localparam logic [7:0] RST_EXTENDED_PRIORITY_SECOND  = 8'h00_00;
  localparam logic [7:0] RST_PORT_ZERO_SKIP_MASK       = 8'h00_00;
  localparam logic [7:0] READ_UNMAPPED                 = 8'h00_00;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int POS_ONE_POLARITY    = 7;
  localparam int POS_ONE_SEL_HI      = 6;
  localparam int POS_ONE_SEL_LO      = 4;
  localparam int POS_ZERO_POLARITY   = 3;
  localparam int POS_ZERO_SEL_HI     = 2;
  localparam int POS_ZERO_SEL_LO     = 0;
  localparam int POS_SERIAL_TWO_PRIO = 1;
  localparam int POS_BUS_VOLT_PRIO   = 0;
  localparam int PRIO_BITS           = 2;
  localparam int SEL_BITS            = 3;
endpackage : irq_cfg_pkg

// ### core/ext_int_pin_watch.sv
// one external interrupt input: pin selection and polarity
`timescale 1ns/1ns
`default_nettype none
module ext_int_pin_watch #(
  parameter int PINS = 8
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic [PINS-1:0]               port_zero_pins,
  input  wire logic [irq_cfg_pkg::SEL_BITS-1:0] pin_select,
  input  wire logic                          polarity,
  output logic                               irq_active,
  output logic                               irq_input_n
);
  typedef struct packed {
    logic active;
    logic level_n;
  } watch_t;

  watch_t state;
  watch_t next_state;
  logic   pin_level;

  // -------------------------------------------------------------------------
  // pin tap and polarity
  // -------------------------------------------------------------------------
  // a read-only tap: no drive back onto the pin, so the crossbar owner is untouched
  always_comb begin
    pin_level           = port_zero_pins[pin_select];   // R4 R9 R11 R5 R10
    next_state.active   = (pin_level == polarity);      // R3 R8
    next_state.level_n  = ~next_state.active;
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{active: 1'b0, level_n: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign irq_active  = state.active;
  assign irq_input_n = state.level_n;
endmodule : ext_int_pin_watch
`default_nettype wire

// ### core/ext_irq_pin_cfg_priority.sv
// register file and pin routing for external interrupt and priority configuration
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R1 - bit 1 of second priority register: serial port two low at 0, high at 1
// R2 - bit 0 of second priority register: bus-voltage interrupt low at 0, high at 1
// R3 - config bit 7: external interrupt one active low at 0, high at 1
// R4 - config bits 6..4 pick port 0 pin for interrupt one; 000,001,010 pins 0..2
// R5 - chosen pin is watched regardless of crossbar, never taken over
// R6 - crossbar never routes a peripheral onto a skipped pin; here a newly skipped pin stays granted for one cycle after the mask updates
// R7 - writing 1 into a skip mask bit marks that pin skipped
// R8 - config bit 3: external interrupt zero active low at 0, high at 1
// R9 - config bits 2..0 pick port 0 pin for interrupt zero, code equals index
// R10 - watching a pin never disturbs the peripheral routed there
// R11 - interrupt one codes 011..111 pick pins 3..7, code equals index
module ext_irq_pin_cfg_priority #(
  parameter int PINS = 8
) (
  input  wire logic            clk,
  input  wire logic            resetn,
  // special-function register port
  input  wire logic [7:0]      sfr_addr,
  input  wire logic            sfr_wr,
  input  wire logic [7:0]      sfr_wdata,
  input  wire logic            sfr_rd,
  output logic      [7:0]      sfr_rdata,
  // port 0 pins and crossbar
  input  wire logic [PINS-1:0] port_zero_pins,
  input  wire logic [PINS-1:0] xbar_route_req,
  output logic      [PINS-1:0] xbar_route_grant,
  output logic      [PINS-1:0] port_zero_skip_mask,
  // to interrupt logic
  output logic                 ext_int_zero_input,
  output logic                 ext_int_one_input,
  output logic                 ext_int_zero_active,
  output logic                 ext_int_one_active,
  output logic                 serial_port_two_priority,
  output logic                 bus_voltage_irq_priority
);
  typedef struct packed {
    logic [7:0]      pin_config;
    logic [1:0]      prio;
    logic [PINS-1:0] skip;
    logic [PINS-1:0] grant;
    logic [7:0]      rdata;
  } cfg_state_t;

  cfg_state_t state;
  cfg_state_t next_state;

  // -------------------------------------------------------------------------
  // register decode
  // -------------------------------------------------------------------------
  // pin config holds, high to low: one polarity, one select, zero polarity,
  // zero select; the priority register keeps only its two low bits, and the
  // skip mask is one bit per port 0 pin; unused priority bits are not stored
  // so they read back zero whatever software wrote there
  typedef enum logic [3:0] {
    SEL_NONE       = 4'b0001,
    SEL_PIN_CONFIG = 4'b0010,
    SEL_PRIORITY   = 4'b0100,
    SEL_SKIP       = 4'b1000
  } reg_sel_t;

  reg_sel_t                         reg_sel;
  logic [irq_cfg_pkg::SEL_BITS-1:0] zero_pin_select;
  logic [irq_cfg_pkg::SEL_BITS-1:0] one_pin_select;
  logic                             zero_polarity;
  logic                             one_polarity;

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  // skip mask widened or cut to one register byte for readback
  function automatic logic [7:0] to_byte(input logic [PINS-1:0] v);
    logic [7:0] b;
    b = '0;
    for (int i = 0; i < PINS && i < 8; i++) begin
      b[i] = v[i];
    end
    return b;
  endfunction : to_byte

  function automatic logic [PINS-1:0] from_byte(input logic [7:0] b);
    logic [PINS-1:0] v;
    v = '0;
    for (int i = 0; i < PINS && i < 8; i++) begin
      v[i] = b[i];
    end
    return v;
  endfunction : from_byte

  // one address decode shared by writes and reads so the two maps cannot drift
  function automatic reg_sel_t decode_addr(input logic [7:0] a);
    reg_sel_t s;
    unique case (a)
      irq_cfg_pkg::ADDR_EXT_INT_PIN_CONFIG:       s = SEL_PIN_CONFIG;
      irq_cfg_pkg::ADDR_EXTENDED_PRIORITY_SECOND: s = SEL_PRIORITY;
      irq_cfg_pkg::ADDR_PORT_ZERO_SKIP_MASK:      s = SEL_SKIP;
      default:                                    s = SEL_NONE;
    endcase
    return s;
  endfunction : decode_addr

  // pin select field of one interrupt, starting at the given low bit
  function automatic logic [irq_cfg_pkg::SEL_BITS-1:0] select_field(input logic [7:0] cfg,
                                                                     input int         lo);
    logic [irq_cfg_pkg::SEL_BITS-1:0] f;
    f = '0;
    for (int i = 0; i < irq_cfg_pkg::SEL_BITS; i++) begin
      f[i] = cfg[lo + i];
    end
    return f;
  endfunction : select_field

  // polarity bit of one interrupt: 0 active low, 1 active high
  function automatic logic polarity_bit(input logic [7:0] cfg, input int pos);
    return cfg[pos];
  endfunction : polarity_bit

  // -------------------------------------------------------------------------
  // field taps
  // -------------------------------------------------------------------------
  // decoded once here and shared by the write path, the read path and the watchers
  assign reg_sel         = decode_addr(sfr_addr);
  assign zero_pin_select = select_field(state.pin_config, irq_cfg_pkg::POS_ZERO_SEL_LO); // R9
  assign one_pin_select  = select_field(state.pin_config, irq_cfg_pkg::POS_ONE_SEL_LO); // R4 R11
  assign zero_polarity   = polarity_bit(state.pin_config, irq_cfg_pkg::POS_ZERO_POLARITY); // R8
  assign one_polarity    = polarity_bit(state.pin_config, irq_cfg_pkg::POS_ONE_POLARITY); // R3

  // -------------------------------------------------------------------------
  // register writes, reads and crossbar gating
  // -------------------------------------------------------------------------
  // reads answer one cycle after the strobe; unused priority bits read zero
  always_comb begin
    next_state = state;
    if (sfr_wr) begin
      unique case (reg_sel)
        SEL_PIN_CONFIG: begin
          next_state.pin_config = sfr_wdata;                        // R3 R4 R8 R9
        end
        SEL_PRIORITY: begin
          next_state.prio = sfr_wdata[irq_cfg_pkg::PRIO_BITS-1:0];   // R1 R2
        end
        SEL_SKIP: begin
          next_state.skip = from_byte(sfr_wdata);                   // R7
        end
        default: begin
          next_state.skip = state.skip;  // unmapped writes are dropped
        end
      endcase
    end
    // a read replaces the held data; without a strobe the bus keeps the last answer
    if (sfr_rd) begin
      unique case (reg_sel)
        SEL_PIN_CONFIG: begin
          next_state.rdata = state.pin_config;
        end
        SEL_PRIORITY: begin
          next_state.rdata = {6'b00_0000, state.prio};
        end
        SEL_SKIP: begin
          next_state.rdata = to_byte(state.skip);
        end
        default: begin
          next_state.rdata = irq_cfg_pkg::READ_UNMAPPED;
        end
      endcase
    end
    // skipped pins are withheld from peripherals so the interrupt tap owns them
    next_state.grant = xbar_route_req & ~state.skip;                // R6
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{pin_config: irq_cfg_pkg::RST_EXT_INT_PIN_CONFIG,
                 prio:       irq_cfg_pkg::RST_EXTENDED_PRIORITY_SECOND[1:0],
                 skip:       from_byte(irq_cfg_pkg::RST_PORT_ZERO_SKIP_MASK),
                 grant:      '0,
                 rdata:      irq_cfg_pkg::READ_UNMAPPED};
    end else begin
      state <= next_state;
    end
  end

  // -------------------------------------------------------------------------
  // pin watchers
  // -------------------------------------------------------------------------
  // input-only taps on the port: selection does not alter crossbar routing
  // both interrupts may watch the same pin; each tap only reads it
  ext_int_pin_watch #(.PINS(PINS)) u_watch_zero (
    .clk            (clk),
    .resetn         (resetn),
    .port_zero_pins (port_zero_pins),
    .pin_select     (zero_pin_select),  // R9
    .polarity       (zero_polarity),    // R8
    .irq_active     (ext_int_zero_active),
    .irq_input_n    (ext_int_zero_input)
  );

  ext_int_pin_watch #(.PINS(PINS)) u_watch_one (
    .clk            (clk),
    .resetn         (resetn),
    .port_zero_pins (port_zero_pins),
    .pin_select     (one_pin_select),   // R4 R11
    .polarity       (one_polarity),     // R3
    .irq_active     (ext_int_one_active),
    .irq_input_n    (ext_int_one_input)
  );

  // -------------------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------------------
  // bus and crossbar side, straight from the state register
  assign sfr_rdata                = state.rdata;
  assign xbar_route_grant         = state.grant;
  assign port_zero_skip_mask      = state.skip;

  // priority levels handed to the interrupt resolver
  assign serial_port_two_priority = state.prio[irq_cfg_pkg::POS_SERIAL_TWO_PRIO]; // R1
  assign bus_voltage_irq_priority = state.prio[irq_cfg_pkg::POS_BUS_VOLT_PRIO];   // R2
endmodule : ext_irq_pin_cfg_priority
`default_nettype wire

// ### sim/port_zero_model.sv
// port 0 pad model driving pin levels for the interrupt watchers
`timescale 1ns/1ns
`default_nettype none
module port_zero_model (
  input  wire logic       clk,
  input  wire logic [7:0] level,
  output logic      [7:0] pins
);
  // pads settle one clock after the bench asks, as a synchronised input would
  always_ff @(posedge clk) begin
    pins <= level;
  end
endmodule : port_zero_model
`default_nettype wire

// ### sim/ext_irq_pin_cfg_priority_asserts.sv
// concurrent checks on the configuration block ports
`timescale 1ns/1ns
`default_nettype none
module irq_cfg_checker #(
  parameter int PINS = 8
) (
  input wire logic            clk,
  input wire logic            resetn,
  input wire logic [7:0]      sfr_addr,
  input wire logic            sfr_wr,
  input wire logic [7:0]      sfr_wdata,
  input wire logic            sfr_rd,
  input wire logic [7:0]      sfr_rdata,
  input wire logic [PINS-1:0] port_zero_pins,
  input wire logic [PINS-1:0] xbar_route_req,
  input wire logic [PINS-1:0] xbar_route_grant,
  input wire logic [PINS-1:0] port_zero_skip_mask,
  input wire logic            ext_int_zero_input,
  input wire logic            ext_int_one_input,
  input wire logic            ext_int_zero_active,
  input wire logic            ext_int_one_active,
  input wire logic            serial_port_two_priority,
  input wire logic            bus_voltage_irq_priority
);
  // ---------------------------------------------------------------------
  // write decodes
  // ---------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire wp = sfr_wr && sfr_addr == irq_cfg_pkg::ADDR_EXTENDED_PRIORITY_SECOND;
  wire ws = sfr_wr && sfr_addr == irq_cfg_pkg::ADDR_PORT_ZERO_SKIP_MASK;
  wire wc = sfr_wr && sfr_addr == irq_cfg_pkg::ADDR_EXT_INT_PIN_CONFIG;
  logic [7:0] shadow_cfg;
  wire zero_hit = port_zero_pins[shadow_cfg[2:0]] == shadow_cfg[3];
  wire one_hit  = port_zero_pins[shadow_cfg[6:4]] == shadow_cfg[7];
  // shadow of the pin config, fed by the same writes the block takes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shadow_cfg <= irq_cfg_pkg::RST_EXT_INT_PIN_CONFIG;
    end else if (wc) begin
      shadow_cfg <= sfr_wdata;
    end
  end
  // ---------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------
  chk_serial_prio_wr: assert property (wp |=> serial_port_two_priority == $past(sfr_wdata[1]))
    else $error("serial port two priority not taken from write");
  chk_bus_prio_wr: assert property (wp |=> bus_voltage_irq_priority == $past(sfr_wdata[0]))
    else $error("bus voltage priority not taken from write");
  chk_prio_hold: assert property (!wp |=> $stable({serial_port_two_priority,
    bus_voltage_irq_priority})) else $error("priority changed without a write");
  chk_prio_read: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h00_F7 |=>
    sfr_rdata == {6'h00, $past(serial_port_two_priority), $past(bus_voltage_irq_priority)})
    else $error("priority readback wrong");
  chk_skip_wr: assert property (ws |=> port_zero_skip_mask == $past(sfr_wdata))
    else $error("skip mask not taken from write");
  chk_skip_hold: assert property (!ws |=> $stable(port_zero_skip_mask))
    else $error("skip mask changed without a write");
  chk_grant_skip: assert property (1'b1 |=> xbar_route_grant == $past(xbar_route_req & ~port_zero_skip_mask))
    else $error("crossbar grant ignores skip mask");
  chk_zero_polar: assert property (1'b1 |=> ext_int_zero_active == $past(zero_hit) &&
    ext_int_zero_input == !$past(zero_hit)) else $error("interrupt zero does not follow its pin");
  chk_one_polar: assert property (1'b1 |=> ext_int_one_active == $past(one_hit) &&
    ext_int_one_input == !$past(one_hit)) else $error("interrupt one does not follow its pin");
  cover property (wp);
  cover property (ws);
  cover property (ext_int_one_active && ext_int_zero_active);
endmodule : irq_cfg_checker
bind ext_irq_pin_cfg_priority irq_cfg_checker #(.PINS(PINS)) u_chk (
  .clk                      (clk),
  .resetn                   (resetn),
  .sfr_addr                 (sfr_addr),
  .sfr_wr                   (sfr_wr),
  .sfr_wdata                (sfr_wdata),
  .sfr_rd                   (sfr_rd),
  .sfr_rdata                (sfr_rdata),
  .port_zero_pins           (port_zero_pins),
  .xbar_route_req           (xbar_route_req),
  .xbar_route_grant         (xbar_route_grant),
  .port_zero_skip_mask      (port_zero_skip_mask),
  .ext_int_zero_input       (ext_int_zero_input),
  .ext_int_one_input        (ext_int_one_input),
  .ext_int_zero_active      (ext_int_zero_active),
  .ext_int_one_active       (ext_int_one_active),
  .serial_port_two_priority (serial_port_two_priority),
  .bus_voltage_irq_priority (bus_voltage_irq_priority)
);
`default_nettype wire

// ### sim/tb_ext_irq_pin_cfg_priority.sv
// self-checking bench for the interrupt pin and priority configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_ext_irq_pin_cfg_priority;
  logic       clk, resetn, sfr_wr, sfr_rd, ext_int_zero_input, ext_int_one_input;
  logic       ext_int_zero_active, ext_int_one_active;
  logic       serial_port_two_priority, bus_voltage_irq_priority;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port_zero_pins, level;
  logic [7:0] xbar_route_req, xbar_route_grant, port_zero_skip_mask;
  int         n_fail, total_checks;
  ext_irq_pin_cfg_priority uut (
    .clk                      (clk),
    .resetn                   (resetn),
    .sfr_addr                 (sfr_addr),
    .sfr_wr                   (sfr_wr),
    .sfr_wdata                (sfr_wdata),
    .sfr_rd                   (sfr_rd),
    .sfr_rdata                (sfr_rdata),
    .port_zero_pins           (port_zero_pins),
    .xbar_route_req           (xbar_route_req),
    .xbar_route_grant         (xbar_route_grant),
    .port_zero_skip_mask      (port_zero_skip_mask),
    .ext_int_zero_input       (ext_int_zero_input),
    .ext_int_one_input        (ext_int_one_input),
    .ext_int_zero_active      (ext_int_zero_active),
    .ext_int_one_active       (ext_int_one_active),
    .serial_port_two_priority (serial_port_two_priority),
    .bus_voltage_irq_priority (bus_voltage_irq_priority)
  );
  port_zero_model pads (.clk(clk), .level(level), .pins(port_zero_pins));
  // ---------------------------------------------------------------------
  // access tasks: an idle edge first, then the strobe held over one edge
  // ---------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1 sfr_rd = 1'b0;
    check(sfr_rdata, exp, what);
  endtask : rd
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    {resetn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, level, xbar_route_req} = '0;
    n_fail = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    rd(8'h00_E4, 8'h00_00, "config reset");
    rd(8'h00_F7, 8'h00_00, "priority reset");
    rd(8'h00_A0, 8'h00_00, "unmapped read");
    // upper priority bits are unused, so set them to prove they read zero
    for (int v = 0; v < 4; v++) begin
      wr(8'h00_F7, 8'h00_FC | 8'(v));
      check(serial_port_two_priority, v[1], "serial prio");
      check(bus_voltage_irq_priority, v[0], "bus prio");
      rd(8'h00_F7, 8'(v), "prio read");
    end
    xbar_route_req = 8'h00_FF;
    wr(irq_cfg_pkg::ADDR_PORT_ZERO_SKIP_MASK, 8'h00_A5);
    @(posedge clk);
    #1 check(xbar_route_grant, 8'h00_5A, "grant");
    check(port_zero_skip_mask, 8'h00_A5, "skip mask");
    rd(irq_cfg_pkg::ADDR_PORT_ZERO_SKIP_MASK, 8'h00_A5, "skip read");
    // both inputs on different pins, every code and polarity, skip mask set
    for (int k = 0; k < 16; k++) begin
      wr(8'h00_E4, {k[3], k[2:0], k[3], ~k[2:0]});
      level = 8'h01 << k[2:0];
      repeat (2) @(posedge clk);
      #1 check(ext_int_one_active, k[3], "ext_int_one_input high pin");
      check(ext_int_zero_active, !k[3], "ext_int_zero_input low pin");
      check(ext_int_one_input, !k[3], "ext_int_one_input line high pin");
      check(ext_int_zero_input, k[3], "ext_int_zero_input line low pin");
      level = ~level;
      repeat (2) @(posedge clk);
      #1 check(ext_int_one_active, !k[3], "ext_int_one_input low pin");
      check(ext_int_zero_active, k[3], "ext_int_zero_input high pin");
      check(ext_int_one_input, k[3], "ext_int_one_input line low pin");
      check(ext_int_zero_input, !k[3], "ext_int_zero_input line high pin");
    end
    complete_run();
  end
endmodule : tb_ext_irq_pin_cfg_priority
`default_nettype wire
